// [design/pmcs_pkg.sv]
// Constants, types and register map of the power-mode and clock sequencer.
// Assumes one 25 MHz block clock and an 8-bit register port with 4-bit address.
package pmcs_pkg;
   // Register offsets
   localparam logic [3:0] PMCS_OFF_PWR_A = 4'h0;
   localparam logic [3:0] PMCS_OFF_PWR_B = 4'h1;
   localparam logic [3:0] PMCS_OFF_REG_CTL = 4'h2;
   localparam logic [3:0] PMCS_OFF_CLK_SEL = 4'h3;
   localparam logic [3:0] PMCS_OFF_PGATE = 4'h4;
   localparam logic [3:0] PMCS_OFF_TMR_CFG = 4'h5;
   localparam logic [3:0] PMCS_OFF_T3_RLO = 4'h6;
   localparam logic [3:0] PMCS_OFF_T3_RHI = 4'h7;
   localparam logic [3:0] PMCS_OFF_T4_RLO = 4'h8;
   localparam logic [3:0] PMCS_OFF_T4_RHI = 4'h9;
   localparam logic [3:0] PMCS_OFF_MODE = 4'ha;
   localparam logic [3:0] PMCS_OFF_IRQ_STAT = 4'hb;
   localparam logic [3:0] PMCS_OFF_IRQ_MASK = 4'hc;
   localparam logic [3:0] PMCS_OFF_LU_WAKE = 4'hd;
   // Field positions
   localparam int PMCS_BIT_IDLE = 0;
   localparam int PMCS_BIT_STOP = 1;
   localparam int PMCS_BIT_SUSPEND = 0;
   localparam int PMCS_BIT_SNOOZE = 1;
   localparam int PMCS_BIT_DEPTH = 0;
   localparam int PMCS_IRQ_IDLE_WAKE = 0;
   localparam int PMCS_IRQ_SLEEP_WAKE = 1;
   localparam int PMCS_IRQ_T3_OVF = 2;
   localparam int PMCS_IRQ_T4_OVF = 3;
   // Clock source codes and reset values
   localparam logic [1:0] PMCS_SRC_FAST_24M = 2'h0;
   localparam logic [1:0] PMCS_SRC_FAST_49M = 2'h1;
   localparam logic [1:0] PMCS_SRC_SLOW_80K = 2'h2;
   localparam logic [1:0] PMCS_SRC_EXT = 2'h3;
   localparam logic [2:0] PMCS_DIV_RESET = 3'h3;
   localparam logic [2:0] PMCS_PRE_WRAP = 3'h2;
   localparam logic [2:0] PMCS_SLOW_DIV_LAST = 3'h7;
   localparam logic [15:0] PMCS_TMR_MAX = 16'hffff;

   // Power mode states, Gray coded along the usual path
   typedef enum logic [2:0] {
      PMCS_NORMAL = 3'h0,
      PMCS_IDLE = 3'h1,
      PMCS_SUSPEND = 3'h3,
      PMCS_SNOOZE = 3'h2,
      PMCS_STOP = 3'h6,
      PMCS_SHUTDOWN = 3'h7
   } pmcs_mode_e;

   // System clock configuration
   typedef struct packed {
      logic prescale;
      logic [2:0] div;
      logic [1:0] src;
   } pmcs_clk_cfg_s;

   // Timer configuration
   typedef struct packed {
      logic t4_run;
      logic t3_run;
      logic chain;
      logic t4_slow;
      logic t3_slow;
   } pmcs_tmr_cfg_s;

   // Wake event group
   typedef struct packed {
      logic spi;
      logic i2c_slave;
      logic port_match;
      logic cmp0;
   } pmcs_wake_s;
endpackage

// [design/pmcs_top.sv]
// Power-mode sequencer, system clock divider, peripheral gating, timers 3/4.
// Assumes a 25 MHz block clock that keeps running in every low-power mode and
// a slow oscillator tick input at 80 kHz, one cycle wide.
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
module pmcs_top #(
   parameter int NUM_PERIPH = 8,
   parameter int NUM_LU = 4
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic pin_or_por_reset_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic irq_any_in,
   input wire pmcs_pkg::pmcs_wake_s wake_in,
   input wire logic [NUM_LU-1:0] logic_unit_n_event_in,
   input wire logic slow_osc_80k_tick_in,
   output logic core_clk_en_out,
   output logic [NUM_PERIPH-1:0] periph_clk_en_out,
   output logic fast_osc_24m_en_out,
   output logic fast_osc_49m_en_out,
   output logic regulator_low_bias_out,
   output logic power_nets_off_out,
   output logic pin_hold_out,
   output logic [1:0] system_clock_src_out,
   output logic system_clock_en_out,
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks and helpers
   if (NUM_PERIPH < 1 || NUM_PERIPH > 8) begin : g_chk_p
      $error("NUM_PERIPH must be 1 to 8");
   end
   if (NUM_LU < 1 || NUM_LU > 8) begin : g_chk_l
      $error("NUM_LU must be 1 to 8");
   end

   // Divider terminal count for a ratio code
   function automatic logic [6:0] div_mask(input logic [2:0] code);
      div_mask = 7'(({7'h0, 1'b1} << code) - 8'h1);
   endfunction

   // Register read-back of a byte from a narrower value
   function automatic logic [7:0] pad8(input logic [7:0] v);
      pad8 = v;
   endfunction

   pmcs_pkg::pmcs_mode_e mode_q;
   logic [7:0] pwr_a_q;
   logic [7:0] pwr_b_q;
   logic depth_q;
   pmcs_pkg::pmcs_clk_cfg_s clk_q;
   logic [NUM_PERIPH-1:0] gate_q;
   pmcs_pkg::pmcs_tmr_cfg_s tmr_q;
   logic [15:0] t3_rld_q;
   logic [15:0] t4_rld_q;
   logic [15:0] t3_cnt_q;
   logic [15:0] t4_cnt_q;
   logic [3:0] irq_stat_q;
   logic [3:0] irq_mask_q;
   logic [NUM_LU-1:0] lu_wake_q;
   logic cmp0_q;
   logic [1:0] pre_cnt_q;
   logic [6:0] div_cnt_q;
   logic [2:0] slow_div_q;
   logic sys_en_q;
   logic slow_en;
   logic pre_ok;
   logic running;
   logic sleeping;
   logic t3_tick;
   logic t4_tick;
   logic t3_ovf;
   logic t4_ovf;
   logic sleep_wake;
   logic idle_wake;
   logic wr_a;
   logic wr_b;

   assign wr_a = wr_in && addr_in == pmcs_pkg::PMCS_OFF_PWR_A;
   assign wr_b = wr_in && addr_in == pmcs_pkg::PMCS_OFF_PWR_B;

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and wake sources
   assign running = mode_q == pmcs_pkg::PMCS_NORMAL || mode_q == pmcs_pkg::PMCS_IDLE;
   assign sleeping = mode_q == pmcs_pkg::PMCS_SUSPEND || mode_q == pmcs_pkg::PMCS_SNOOZE;
   // Any wake event ends suspend or snooze
   assign sleep_wake = t4_ovf || wake_in.spi || wake_in.i2c_slave || wake_in.port_match
      || (cmp0_q && !wake_in.cmp0) || |(logic_unit_n_event_in & lu_wake_q);
   assign idle_wake = irq_any_in || irq_out;

   // Comparator 0 level history for falling edge detection
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         cmp0_q <= 1'b0;
      else
         cmp0_q <= wake_in.cmp0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power mode sequencer
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         // Shutdown ignores every reset but pin and power-on
         if (pin_or_por_reset_in || mode_q != pmcs_pkg::PMCS_SHUTDOWN)
            mode_q <= pmcs_pkg::PMCS_NORMAL;
      end
      else
      begin
         unique case (mode_q)
            pmcs_pkg::PMCS_NORMAL:
            begin
               if (wr_a && wdata_in[pmcs_pkg::PMCS_BIT_STOP])
                  mode_q <= depth_q ? pmcs_pkg::PMCS_SHUTDOWN
                                    : pmcs_pkg::PMCS_STOP;
               else if (wr_b && wdata_in[pmcs_pkg::PMCS_BIT_SNOOZE])
                  mode_q <= pmcs_pkg::PMCS_SNOOZE;
               else if (wr_b && wdata_in[pmcs_pkg::PMCS_BIT_SUSPEND])
                  mode_q <= pmcs_pkg::PMCS_SUSPEND;
               else if (wr_a && wdata_in[pmcs_pkg::PMCS_BIT_IDLE])
                  mode_q <= pmcs_pkg::PMCS_IDLE;
            end
            pmcs_pkg::PMCS_IDLE:
               if (idle_wake)
                  mode_q <= pmcs_pkg::PMCS_NORMAL;
            pmcs_pkg::PMCS_SUSPEND, pmcs_pkg::PMCS_SNOOZE:
               if (sleep_wake)
                  mode_q <= pmcs_pkg::PMCS_NORMAL;
            pmcs_pkg::PMCS_STOP, pmcs_pkg::PMCS_SHUTDOWN:
               mode_q <= mode_q;
            default:
               mode_q <= pmcs_pkg::PMCS_NORMAL;
         endcase
      end
   end

   // Power control request bits, cleared when the wake lands back in normal
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         pwr_a_q <= 8'h00;
         pwr_b_q <= 8'h00;
      end
      else
      begin
         if (mode_q == pmcs_pkg::PMCS_IDLE && idle_wake)
            pwr_a_q[pmcs_pkg::PMCS_BIT_IDLE] <= 1'b0;
         else if (wr_a && mode_q == pmcs_pkg::PMCS_NORMAL)
            pwr_a_q <= wdata_in;
         if (sleeping && sleep_wake)
         begin
            pwr_b_q[pmcs_pkg::PMCS_BIT_SUSPEND] <= 1'b0;
            pwr_b_q[pmcs_pkg::PMCS_BIT_SNOOZE] <= 1'b0;
         end
         else if (wr_b && mode_q == pmcs_pkg::PMCS_NORMAL)
            pwr_b_q <= wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         depth_q <= 1'b0;
         clk_q <= '{prescale: 1'b0, div: pmcs_pkg::PMCS_DIV_RESET,
                    src: pmcs_pkg::PMCS_SRC_FAST_24M};
         gate_q <= '0;
         tmr_q <= '0;
         t3_rld_q <= 16'h0000;
         t4_rld_q <= 16'h0000;
         irq_mask_q <= 4'h0;
         lu_wake_q <= '0;
      end
      else if (wr_in)
      begin
         unique case (addr_in)
            pmcs_pkg::PMCS_OFF_REG_CTL: depth_q <= wdata_in[pmcs_pkg::PMCS_BIT_DEPTH];
            pmcs_pkg::PMCS_OFF_CLK_SEL: clk_q <= wdata_in[5:0];
            pmcs_pkg::PMCS_OFF_PGATE: gate_q <= wdata_in[NUM_PERIPH-1:0];
            pmcs_pkg::PMCS_OFF_TMR_CFG: tmr_q <= wdata_in[4:0];
            pmcs_pkg::PMCS_OFF_T3_RLO: t3_rld_q[7:0] <= wdata_in;
            pmcs_pkg::PMCS_OFF_T3_RHI: t3_rld_q[15:8] <= wdata_in;
            pmcs_pkg::PMCS_OFF_T4_RLO: t4_rld_q[7:0] <= wdata_in;
            pmcs_pkg::PMCS_OFF_T4_RHI: t4_rld_q[15:8] <= wdata_in;
            pmcs_pkg::PMCS_OFF_IRQ_MASK: irq_mask_q <= wdata_in[3:0];
            pmcs_pkg::PMCS_OFF_LU_WAKE: lu_wake_q <= wdata_in[NUM_LU-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System clock prescaler and divider
   // The 1.5x prescaler drops one of every three cycles of a fast source
   assign pre_ok = !clk_q.prescale || clk_q.src[1] || pre_cnt_q != 2'(pmcs_pkg::PMCS_PRE_WRAP);

   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         pre_cnt_q <= 2'h0;
      else if (pre_cnt_q == 2'(pmcs_pkg::PMCS_PRE_WRAP))
         pre_cnt_q <= 2'h0;
      else
         pre_cnt_q <= pre_cnt_q + 2'h1;
   end

   // Divide by a power of two, one enable pulse per period
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         div_cnt_q <= 7'h00;
         sys_en_q <= 1'b0;
      end
      else if (pre_ok)
      begin
         div_cnt_q <= (div_cnt_q >= div_mask(clk_q.div)) ? 7'h00 : div_cnt_q + 7'h01;
         sys_en_q <= running && div_cnt_q >= div_mask(clk_q.div);
      end
      else
         sys_en_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers 3 and 4 on the system clock or slow oscillator divided by 8
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         slow_div_q <= 3'h0;
      else if (slow_osc_80k_tick_in)
         slow_div_q <= slow_div_q + 3'h1;
   end

   assign slow_en = slow_osc_80k_tick_in && slow_div_q == pmcs_pkg::PMCS_SLOW_DIV_LAST;
   assign t3_tick = tmr_q.t3_run && (tmr_q.t3_slow ? slow_en : sys_en_q);
   assign t4_tick = tmr_q.t4_run && (tmr_q.chain ? t3_ovf
      : (tmr_q.t4_slow ? slow_en : sys_en_q));
   assign t3_ovf = t3_tick && t3_cnt_q == pmcs_pkg::PMCS_TMR_MAX;
   assign t4_ovf = t4_tick && t4_cnt_q == pmcs_pkg::PMCS_TMR_MAX;

   // Auto-reload counters
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
      begin
         t3_cnt_q <= 16'h0000;
         t4_cnt_q <= 16'h0000;
      end
      else
      begin
         if (t3_tick)
            t3_cnt_q <= t3_ovf ? t3_rld_q : t3_cnt_q + 16'h0001;
         if (t4_tick)
            t4_cnt_q <= t4_ovf ? t4_rld_q : t4_cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, read clears, a new event wins over the clear
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         irq_stat_q <= 4'h0;
      else
         irq_stat_q <= (rd_in && addr_in == pmcs_pkg::PMCS_OFF_IRQ_STAT ? 4'h0 : irq_stat_q)
            | {t4_ovf, t3_ovf, sleeping && sleep_wake,
               mode_q == pmcs_pkg::PMCS_IDLE && idle_wake};
   end

   assign irq_out = |(irq_stat_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Register read port, one cycle latency, unmapped reads zero
   always_ff @(posedge sys_clk_in)
   begin
      if (!resetn_in)
         rdata_out <= 8'h00;
      else if (rd_in)
      begin
         unique case (addr_in)
            pmcs_pkg::PMCS_OFF_PWR_A: rdata_out <= pwr_a_q;
            pmcs_pkg::PMCS_OFF_PWR_B: rdata_out <= pwr_b_q;
            pmcs_pkg::PMCS_OFF_REG_CTL: rdata_out <= {7'h00, depth_q};
            pmcs_pkg::PMCS_OFF_CLK_SEL: rdata_out <= {2'h0, clk_q};
            pmcs_pkg::PMCS_OFF_PGATE: rdata_out <= pad8(8'(gate_q));
            pmcs_pkg::PMCS_OFF_TMR_CFG: rdata_out <= {3'h0, tmr_q};
            pmcs_pkg::PMCS_OFF_T3_RLO: rdata_out <= t3_rld_q[7:0];
            pmcs_pkg::PMCS_OFF_T3_RHI: rdata_out <= t3_rld_q[15:8];
            pmcs_pkg::PMCS_OFF_T4_RLO: rdata_out <= t4_rld_q[7:0];
            pmcs_pkg::PMCS_OFF_T4_RHI: rdata_out <= t4_rld_q[15:8];
            pmcs_pkg::PMCS_OFF_MODE: rdata_out <= {5'h00, mode_q};
            pmcs_pkg::PMCS_OFF_IRQ_STAT: rdata_out <= {4'h0, irq_stat_q};
            pmcs_pkg::PMCS_OFF_IRQ_MASK: rdata_out <= {4'h0, irq_mask_q};
            pmcs_pkg::PMCS_OFF_LU_WAKE: rdata_out <= pad8(8'(lu_wake_q));
            default: rdata_out <= 8'h00;
         endcase
      end
      else
         rdata_out <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock, oscillator and power outputs
   assign core_clk_en_out = mode_q == pmcs_pkg::PMCS_NORMAL;
   assign fast_osc_24m_en_out = running && clk_q.src == pmcs_pkg::PMCS_SRC_FAST_24M;
   assign fast_osc_49m_en_out = running && clk_q.src == pmcs_pkg::PMCS_SRC_FAST_49M;
   assign regulator_low_bias_out = mode_q == pmcs_pkg::PMCS_SNOOZE;
   assign power_nets_off_out = mode_q == pmcs_pkg::PMCS_STOP
      || mode_q == pmcs_pkg::PMCS_SHUTDOWN;
   assign pin_hold_out = power_nets_off_out;
   assign system_clock_src_out = clk_q.src;
   assign system_clock_en_out = sys_en_q;

   // Per-peripheral clock gates
   for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_gate
      assign periph_clk_en_out[i] = running && gate_q[i];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!resetn_in);

   AST_IDLE_ENTRY: assert property (
      mode_q == pmcs_pkg::PMCS_NORMAL && wr_a && wdata_in == 8'h01
      |=> !core_clk_en_out && |periph_clk_en_out == |gate_q)
      else $error("idle entry wrong");
   AST_IDLE_WAKE: assert property (
      mode_q == pmcs_pkg::PMCS_IDLE && irq_any_in
      |=> core_clk_en_out && !pwr_a_q[pmcs_pkg::PMCS_BIT_IDLE])
      else $error("idle wake wrong");
   AST_SUSPEND_BIAS: assert property (
      mode_q == pmcs_pkg::PMCS_SUSPEND |-> !regulator_low_bias_out)
      else $error("suspend bias wrong");
   AST_SNOOZE_ENTRY: assert property (
      mode_q == pmcs_pkg::PMCS_NORMAL && wr_b && wdata_in == 8'h02 && !irq_any_in
      |=> regulator_low_bias_out && !fast_osc_24m_en_out)
      else $error("snooze entry wrong");
   AST_SLEEP_QUIET: assert property (
      sleeping |-> !core_clk_en_out && periph_clk_en_out == '0
         && !fast_osc_24m_en_out && !fast_osc_49m_en_out ##1 !system_clock_en_out)
      else $error("sleep clocks running");
   AST_SLEEP_WAKE: assert property (
      sleeping && wake_in.spi |=> core_clk_en_out ##0 pwr_b_q[1:0] == 2'h0)
      else $error("sleep wake missed");
   AST_STOP_ENTRY: assert property (
      mode_q == pmcs_pkg::PMCS_NORMAL && wr_a && wdata_in[pmcs_pkg::PMCS_BIT_STOP] && !depth_q
      |=> power_nets_off_out && pin_hold_out && mode_q == pmcs_pkg::PMCS_STOP)
      else $error("stop entry wrong");
   AST_STOP_HOLD: assert property (
      mode_q == pmcs_pkg::PMCS_STOP |=> mode_q == pmcs_pkg::PMCS_STOP && power_nets_off_out)
      else $error("stop left without reset");
   AST_SHUT_HOLD: assert property (@(posedge sys_clk_in) disable iff (1'b0)
      mode_q == pmcs_pkg::PMCS_SHUTDOWN && !pin_or_por_reset_in
      |=> mode_q == pmcs_pkg::PMCS_SHUTDOWN)
      else $error("shutdown left without pin reset");
   AST_RESET_CLOCK: assert property (@(posedge sys_clk_in) disable iff (1'b0)
      !resetn_in |=> clk_q.div == pmcs_pkg::PMCS_DIV_RESET
         && clk_q.src == pmcs_pkg::PMCS_SRC_FAST_24M)
      else $error("reset clock wrong");
   AST_DIVIDER: assert property (
      system_clock_en_out && !clk_q.prescale && clk_q.div == 3'h1 && $stable(clk_q) && running
      && !wr_in |=> !system_clock_en_out ##1 system_clock_en_out)
      else $error("divider period wrong");
   AST_PRESCALE: assert property (
      clk_q.prescale && !clk_q.src[1] && pre_cnt_q == 2'h2 |=> !system_clock_en_out)
      else $error("prescaler did not drop");
   AST_GATE: assert property (
      !gate_q[0] |-> !periph_clk_en_out[0])
      else $error("gated clock running");
   AST_SLOW_TICK: assert property (
      tmr_q.t3_slow && tmr_q.t3_run && slow_en && t3_cnt_q != pmcs_pkg::PMCS_TMR_MAX
      |=> t3_cnt_q == $past(t3_cnt_q) + 16'h0001)
      else $error("timer 3 missed slow tick");
   AST_T4_WAKE: assert property (
      mode_q == pmcs_pkg::PMCS_SNOOZE && t4_ovf |=> mode_q == pmcs_pkg::PMCS_NORMAL
         ##0 irq_stat_q[pmcs_pkg::PMCS_IRQ_T4_OVF])
      else $error("timer 4 wake missed");

   COV_IDLE_WAKE: cover property (mode_q == pmcs_pkg::PMCS_IDLE ##1 core_clk_en_out);
   COV_SNOOZE_WAKE: cover property (mode_q == pmcs_pkg::PMCS_SNOOZE && t4_ovf);
   COV_SHUTDOWN: cover property (mode_q == pmcs_pkg::PMCS_SHUTDOWN);
   COV_CHAIN: cover property (tmr_q.chain && t4_ovf);
endmodule // pmcs_top

// [bench/tb.sv]
// Self-checking bench for the power-mode and clock sequencer top.
// Assumes pmcs_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ns
module tb;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic pin_or_por_reset_in = 1'b1;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic irq_any_in = 1'b0;
   pmcs_pkg::pmcs_wake_s wake_in = 4'h1;
   logic [3:0] logic_unit_n_event_in = 4'h0;
   logic slow_osc_80k_tick_in = 1'b0;
   logic [2:0] tick_div_q = 3'h0;
   logic [7:0] rdata_out;
   logic core_clk_en_out;
   logic [7:0] periph_clk_en_out;
   logic fast_osc_24m_en_out;
   logic fast_osc_49m_en_out;
   logic regulator_low_bias_out;
   logic power_nets_off_out;
   logic pin_hold_out;
   logic [1:0] system_clock_src_out;
   logic system_clock_en_out;
   logic irq_out;
   int bad_count = 0;
   int checked = 0;
   int pulses;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and a slow oscillator tick every 8 cycles
   always #20 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in)
   begin
      tick_div_q <= tick_div_q + 3'h1;
      slow_osc_80k_tick_in <= (tick_div_q == 3'h0);
   end

   pmcs_top u_dut (
      .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .pin_or_por_reset_in(pin_or_por_reset_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_any_in(irq_any_in), .wake_in(wake_in),
      .logic_unit_n_event_in(logic_unit_n_event_in),
      .slow_osc_80k_tick_in(slow_osc_80k_tick_in), .core_clk_en_out(core_clk_en_out),
      .periph_clk_en_out(periph_clk_en_out), .fast_osc_24m_en_out(fast_osc_24m_en_out),
      .fast_osc_49m_en_out(fast_osc_49m_en_out),
      .regulator_low_bias_out(regulator_low_bias_out),
      .power_nets_off_out(power_nets_off_out), .pin_hold_out(pin_hold_out),
      .system_clock_src_out(system_clock_src_out),
      .system_clock_en_out(system_clock_en_out), .irq_out(irq_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, bus access and timing helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, exp);
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   task automatic do_reset(input logic por);
      @(posedge sys_clk_in);
      resetn_in <= 1'b0;
      pin_or_por_reset_in <= por;
      repeat (8) @(posedge sys_clk_in);
      resetn_in <= 1'b1;
   endtask

   // Counts system clock enable pulses over n settled cycles
   task automatic count(input int n, input int exp);
      pulses = 0;
      repeat (n)
      begin
         @(posedge sys_clk_in);
         #1;
         if (system_clock_en_out === 1'b1) pulses++;
      end
      chk(pulses[15:0], exp[15:0]);
   endtask

   // Enters suspend or snooze, checks the asleep outputs, wakes by one source
   task automatic sleep_wake(input int src, input logic snz);
      wr(pmcs_pkg::PMCS_OFF_PWR_B, snz ? 8'h02 : 8'h01);
      step(2);
      chk(core_clk_en_out, 16'h0);
      chk(periph_clk_en_out, 16'h0);
      chk({fast_osc_24m_en_out, fast_osc_49m_en_out}, 16'h0);
      chk(regulator_low_bias_out, {15'h0, snz});
      rd(pmcs_pkg::PMCS_OFF_MODE, snz ? 8'h02 : 8'h03);
      @(posedge sys_clk_in);
      case (src)
         0: wake_in.spi <= 1'b1;
         1: wake_in.i2c_slave <= 1'b1;
         2: wake_in.port_match <= 1'b1;
         3: wake_in.cmp0 <= 1'b0;
         default: logic_unit_n_event_in <= 4'h1;
      endcase
      @(posedge sys_clk_in);
      wake_in <= 4'h1;
      logic_unit_n_event_in <= 4'h0;
      step(2);
      chk(core_clk_en_out, 16'h1);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h00);
      rd(pmcs_pkg::PMCS_OFF_PWR_B, 8'h00);
   endtask

   task automatic results;
      $display("mismatches %0d, comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung run
   initial
   begin
      repeat (80000) @(posedge sys_clk_in);
      bad_count++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      do_reset(1'b1);
      rd(pmcs_pkg::PMCS_OFF_CLK_SEL, 8'h0c);
      chk(system_clock_src_out, 16'h0);
      chk(core_clk_en_out, 16'h1);
      count(64, 8);
      for (int k = 0; k < 8; k++)
      begin
         wr(pmcs_pkg::PMCS_OFF_CLK_SEL, 8'(k << 2));
         step(4);
         count(128, 128 >> k);
      end
      wr(pmcs_pkg::PMCS_OFF_CLK_SEL, 8'h01);
      step(2);
      chk({fast_osc_24m_en_out, fast_osc_49m_en_out}, 16'h1);
      wr(pmcs_pkg::PMCS_OFF_CLK_SEL, 8'h20);
      step(4);
      count(96, 64);
      wr(pmcs_pkg::PMCS_OFF_CLK_SEL, 8'h00);
      wr(pmcs_pkg::PMCS_OFF_PGATE, 8'h5a);
      wr(4'he, 8'hff);
      rd(4'he, 8'h00);
      wr(pmcs_pkg::PMCS_OFF_MODE, 8'hff);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h00);
      step(2);
      chk(periph_clk_en_out, 16'h5a);
      wr(pmcs_pkg::PMCS_OFF_PWR_A, 8'h01);
      wr(pmcs_pkg::PMCS_OFF_PWR_B, 8'h01);
      step(2);
      chk(core_clk_en_out, 16'h0);
      chk(periph_clk_en_out, 16'h5a);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h01);
      @(posedge sys_clk_in);
      irq_any_in <= 1'b1;
      @(posedge sys_clk_in);
      irq_any_in <= 1'b0;
      step(2);
      chk(core_clk_en_out, 16'h1);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h00);
      rd(pmcs_pkg::PMCS_OFF_PWR_A, 8'h00);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h01);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h00);
      wr(pmcs_pkg::PMCS_OFF_LU_WAKE, 8'h01);
      for (int s = 0; s < 5; s++)
      begin
         sleep_wake(s, 1'b0);
         sleep_wake(s, 1'b1);
      end
      chk(irq_out, 16'h0);
      wr(pmcs_pkg::PMCS_OFF_IRQ_MASK, 8'h02);
      step(2);
      chk(irq_out, 16'h1);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h02);
      step(1);
      chk(irq_out, 16'h0);
      wr(pmcs_pkg::PMCS_OFF_REG_CTL, 8'h00);
      wr(pmcs_pkg::PMCS_OFF_PWR_A, 8'h02);
      step(2);
      chk({power_nets_off_out, pin_hold_out}, 16'h3);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h06);
      @(posedge sys_clk_in);
      wake_in.spi <= 1'b1;
      @(posedge sys_clk_in);
      wake_in.spi <= 1'b0;
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h06);
      do_reset(1'b0);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h00);
      wr(pmcs_pkg::PMCS_OFF_REG_CTL, 8'h01);
      wr(pmcs_pkg::PMCS_OFF_PWR_A, 8'h02);
      step(2);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h07);
      do_reset(1'b0);
      step(2);
      chk({power_nets_off_out, pin_hold_out}, 16'h3);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h07);
      do_reset(1'b1);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h00);
      chk(core_clk_en_out, 16'h1);
      // Timers on the system clock, then chained, then slow through snooze
      wr(pmcs_pkg::PMCS_OFF_CLK_SEL, 8'h00);
      wr(pmcs_pkg::PMCS_OFF_T3_RLO, 8'hf0);
      wr(pmcs_pkg::PMCS_OFF_T3_RHI, 8'hff);
      wr(pmcs_pkg::PMCS_OFF_T4_RLO, 8'hfe);
      wr(pmcs_pkg::PMCS_OFF_T4_RHI, 8'hff);
      wr(pmcs_pkg::PMCS_OFF_TMR_CFG, 8'h18);
      step(65600);
      wr(pmcs_pkg::PMCS_OFF_TMR_CFG, 8'h08);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h0c);
      step(40);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h04);
      wr(pmcs_pkg::PMCS_OFF_TMR_CFG, 8'h1c);
      step(80);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h0c);
      wr(pmcs_pkg::PMCS_OFF_TMR_CFG, 8'h1b);
      wr(pmcs_pkg::PMCS_OFF_PWR_B, 8'h02);
      step(1200);
      rd(pmcs_pkg::PMCS_OFF_MODE, 8'h00);
      rd(pmcs_pkg::PMCS_OFF_IRQ_STAT, 8'h0e);
      results();
   end
endmodule // tb
